// *** design/pcs_defines.svh ***
// Purpose: Constants for the PLL switchover and reconfiguration control block
// Assumes: 50 MHz system clock
// Notes: Chain layout is LSB first: n, m, e0..e3, then four delay fields
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
// =====================================================================
// Timing
`define PCS_CLK_MHZ 50
`define PCS_RELOCK_US 100
`define PCS_LOSS_NS 1000
`define PCS_HOLD_CYCLES 4
`define PCS_CONFIG_US 20
`define PCS_SCAN_MHZ 25
// =====================================================================
// Chain geometry and field positions
`define PCS_DIV_W 9
`define PCS_DLY_W 5
`define PCS_NUM_ECNT 4
`define PCS_NUM_PINS 8
`define PCS_CHAIN_LEN 74
`define PCS_N_LSB 0
`define PCS_M_LSB 9
`define PCS_E_LSB 18
`define PCS_DLY_LSB 54
// =====================================================================
// Reset values and ranges
`define PCS_DIV_RST 9'h000
`define PCS_DLY_RST 5'h00
`define PCS_DIV_MIN 1
`define PCS_DIV_MAX 512
`define PCS_BW_MIN_KHZ 150
`define PCS_BW_MAX_KHZ 2000
`endif

// *** design/pcs_pkg.sv ***
// Purpose: Types for the PLL switchover and reconfiguration control block
// Assumes: pcs_defines.svh supplies all numeric constants
// Notes: Divider fields hold the divide value minus one
`include "pcs_defines.svh"
package pcs_pkg;
   typedef logic [`PCS_DIV_W-1:0] pcs_div_t;
   typedef logic [`PCS_DLY_W-1:0] pcs_dly_t;
   typedef enum logic [3:0] {
      PCS_ON_PRIMARY = 4'h1,
      PCS_HOLD_TO_SEC = 4'h2,
      PCS_ON_SECONDARY = 4'h4,
      PCS_HOLD_TO_PRI = 4'h8
   } pcs_sw_state_t;
endpackage : pcs_pkg

// *** design/pcs_top.sv ***
// Purpose: Reference switchover, serial reconfiguration and output routing for a PLL
// Assumes: Reference and shift clocks are far slower than sys_clk (at most a quarter)
// Notes: Relock time is modelled by a counter; the analog loop lives outside
`include "pcs_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module pcs_top
   import pcs_pkg::*;
#(
   parameter int unsigned RELOCK_CYCLES = `PCS_RELOCK_US * `PCS_CLK_MHZ
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic primary_ref_clock,
   input wire logic secondary_ref_clock,
   input wire logic auto_switch_en,
   input wire logic switch_request,
   output logic ref_sel,
   output logic ref_clock_out,
   output logic primary_lost,
   output logic secondary_lost,
   output logic pll_locked,
   input wire logic scan_clk,
   input wire logic scan_data,
   input wire logic scan_aclr,
   output logic cfg_loaded,
   output logic [`PCS_DIV_W-1:0] prescale_div,
   output logic [`PCS_DIV_W-1:0] feedback_div,
   output logic [`PCS_NUM_ECNT*`PCS_DLY_W-1:0] delay_setting,
   input wire logic [2:0] bw_cp_in,
   input wire logic [2:0] bw_lf_r_in,
   input wire logic [1:0] bw_hf_c_in,
   output logic [2:0] bw_cp,
   output logic [2:0] bw_lf_r,
   output logic [1:0] bw_hf_c,
   input wire logic diff_mode,
   input wire logic [2*`PCS_NUM_PINS-1:0] pin_cnt_sel,
   input wire logic [`PCS_NUM_PINS-1:0] pin_invert,
   input wire logic [`PCS_NUM_PINS-1:0] pin_gpo_en,
   input wire logic [`PCS_NUM_PINS-1:0] pin_gpo_data,
   output logic [`PCS_NUM_PINS-1:0] external_clock_output
);

   // =====================================================================
   // Constants derived from time figures and the chain length
   localparam int unsigned LOSS_CYCLES = (`PCS_LOSS_NS * `PCS_CLK_MHZ) / 1000;
   localparam logic [6:0] CHAIN_LAST = 7'(`PCS_CHAIN_LEN - 1);
   localparam logic [7:0] LOSS_MAX = 8'(LOSS_CYCLES);
   localparam logic [2:0] HOLD_MAX = 3'(`PCS_HOLD_CYCLES);
   localparam logic [15:0] RELOCK_MAX = 16'(RELOCK_CYCLES);

   // Extract one divider field from the chain
   function automatic pcs_div_t div_field(input logic [`PCS_CHAIN_LEN-1:0] ch,
                                          input int lsb);
      div_field = ch[lsb +: `PCS_DIV_W];
   endfunction : div_field

   // =====================================================================
   // Input synchronisers
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [3:0] sync3_reg;
   // Order: primary, secondary, scan clock, scan data
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         {sync1_reg, sync2_reg, sync3_reg} <= 12'h000;
      else
      begin
         sync1_reg <= {scan_data, scan_clk, secondary_ref_clock, primary_ref_clock};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // =====================================================================
   // Clock sense: a reference is lost when no edge seen for LOSS_CYCLES
   logic [7:0] quiet_cnt_reg [2];
   logic [1:0] lost_reg;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         quiet_cnt_reg <= '{8'h00, 8'h00};
         lost_reg <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (sync2_reg[i] != sync3_reg[i])
            begin
               quiet_cnt_reg[i] <= 8'h00;
               lost_reg[i] <= 1'b0;
            end
            else if (quiet_cnt_reg[i] == LOSS_MAX)
               lost_reg[i] <= 1'b1;
            else
               quiet_cnt_reg[i] <= quiet_cnt_reg[i] + 8'h01;
         end
      end
   end
   assign primary_lost = lost_reg[0];
   assign secondary_lost = lost_reg[1];

   // =====================================================================
   // Switchover state machine
   pcs_sw_state_t sw_state_reg;
   logic sel_reg;
   logic pending_reg;
   logic [2:0] hold_cnt_reg;
   logic sel_level;
   logic sel_lost;
   logic switch_event;
   assign sel_level = sel_reg ? sync3_reg[1] : sync3_reg[0];
   assign sel_lost = sel_reg ? lost_reg[1] : lost_reg[0];

   // Switch is pending from a request, or a primary loss in automatic mode, until the selected clock sits low or is lost
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pending_reg <= 1'b0;
      else if (switch_request)
         pending_reg <= 1'b1;
      else if (auto_switch_en && !sel_reg && lost_reg[0]
               && sw_state_reg == PCS_ON_PRIMARY && !switch_event)
         pending_reg <= 1'b1;
      else if (switch_event)
         pending_reg <= 1'b0;
   end
   // Enter the hold only when the selected clock is low or is dead
   assign switch_event = pending_reg && (!sel_level || sel_lost)
      && (sw_state_reg == PCS_ON_PRIMARY || sw_state_reg == PCS_ON_SECONDARY);

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sw_state_reg <= PCS_ON_PRIMARY;
         sel_reg <= 1'b0;
         hold_cnt_reg <= 3'h0;
      end
      else
      begin
         case (sw_state_reg)
            PCS_ON_PRIMARY, PCS_ON_SECONDARY:
            begin
               hold_cnt_reg <= 3'h0;
               if (switch_event && sel_reg)
                  sw_state_reg <= PCS_HOLD_TO_PRI;
               else if (switch_event)
                  sw_state_reg <= PCS_HOLD_TO_SEC;
            end
            PCS_HOLD_TO_SEC, PCS_HOLD_TO_PRI:
            begin
               hold_cnt_reg <= hold_cnt_reg + 3'h1;
               if (hold_cnt_reg == HOLD_MAX)
               begin
                  sel_reg <= !sel_reg;
                  if (sel_reg)
                     sw_state_reg <= PCS_ON_PRIMARY;
                  else
                     sw_state_reg <= PCS_ON_SECONDARY;
               end
            end
            default:
            begin
               sw_state_reg <= PCS_ON_PRIMARY;
               sel_reg <= 1'b0;
               hold_cnt_reg <= 3'h0;
            end
         endcase
      end
   end
   assign ref_sel = sel_reg;

   // Selected reference, held low through the hold states
   logic ref_out_reg;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ref_out_reg <= 1'b0;
      else if (sw_state_reg == PCS_ON_PRIMARY || sw_state_reg == PCS_ON_SECONDARY)
         ref_out_reg <= sel_level;
      else
         ref_out_reg <= 1'b0;
   end
   assign ref_clock_out = ref_out_reg;

   // =====================================================================
   // Serial reconfiguration chain, cleared by its own asynchronous clear
   logic chain_rst;
   logic shift_edge;
   logic [`PCS_CHAIN_LEN-1:0] chain_reg;
   logic [6:0] bit_cnt_reg;
   logic load_reg;
   assign chain_rst = sys_rst | scan_aclr;
   assign shift_edge = sync2_reg[2] && !sync3_reg[2];

   always_ff @(posedge sys_clk or posedge chain_rst)
   begin
      if (chain_rst)
      begin
         chain_reg <= '0;
         bit_cnt_reg <= 7'h00;
         load_reg <= 1'b0;
      end
      else
      begin
         load_reg <= 1'b0;
         if (shift_edge)
         begin
            chain_reg <= {sync3_reg[3], chain_reg[`PCS_CHAIN_LEN-1:1]};
            if (bit_cnt_reg == CHAIN_LAST)
            begin
               bit_cnt_reg <= 7'h00;
               load_reg <= 1'b1;
            end
            else
               bit_cnt_reg <= bit_cnt_reg + 7'h01;
         end
      end
   end
   assign cfg_loaded = load_reg;

   // Active counter and delay settings, loaded whole from the chain
   pcs_div_t n_div_reg;
   pcs_div_t m_div_reg;
   pcs_div_t e_div_reg [`PCS_NUM_ECNT];
   logic [`PCS_NUM_ECNT*`PCS_DLY_W-1:0] dly_reg;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         n_div_reg <= `PCS_DIV_RST;
         m_div_reg <= `PCS_DIV_RST;
         e_div_reg <= '{default: `PCS_DIV_RST};
         dly_reg <= {`PCS_NUM_ECNT{`PCS_DLY_RST}};
      end
      else if (load_reg)
      begin
         n_div_reg <= div_field(chain_reg, `PCS_N_LSB);
         m_div_reg <= div_field(chain_reg, `PCS_M_LSB);
         for (int i = 0; i < `PCS_NUM_ECNT; i++)
            e_div_reg[i] <= div_field(chain_reg, `PCS_E_LSB + i * `PCS_DIV_W);
         dly_reg <= chain_reg[`PCS_DLY_LSB +: `PCS_NUM_ECNT*`PCS_DLY_W];
      end
   end
   assign prescale_div = n_div_reg;
   assign feedback_div = m_div_reg;
   assign delay_setting = dly_reg;

   // Loop components captured once after reset, never touched by the chain
   logic bw_taken_reg;
   logic [7:0] bw_reg;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         {bw_taken_reg, bw_reg} <= 9'h000;
      else if (!bw_taken_reg)
      begin
         bw_taken_reg <= 1'b1;
         bw_reg <= {bw_cp_in, bw_lf_r_in, bw_hf_c_in};
      end
   end
   assign bw_cp = bw_reg[7:5];
   assign bw_lf_r = bw_reg[4:2];
   assign bw_hf_c = bw_reg[1:0];

   // =====================================================================
   // Lock model: drops on any resynchronizing event, returns after relock time
   logic [15:0] lock_cnt_reg;
   logic locked_reg;
   logic relock_event;
   assign relock_event = switch_event || load_reg || sel_lost;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lock_cnt_reg <= 16'h0000;
         locked_reg <= 1'b0;
      end
      else if (relock_event || sw_state_reg == PCS_HOLD_TO_SEC
               || sw_state_reg == PCS_HOLD_TO_PRI)
      begin
         lock_cnt_reg <= 16'h0000;
         locked_reg <= 1'b0;
      end
      else if (lock_cnt_reg == RELOCK_MAX)
         locked_reg <= 1'b1;
      else
         lock_cnt_reg <= lock_cnt_reg + 16'h0001;
   end
   assign pll_locked = locked_reg;

   // =====================================================================
   // External output counters: each divides sys_clk by its value plus one
   logic [`PCS_DIV_W-1:0] e_cnt_reg [`PCS_NUM_ECNT];
   logic [`PCS_NUM_ECNT-1:0] e_clk_reg;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         e_cnt_reg <= '{default: 9'h000};
         e_clk_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < `PCS_NUM_ECNT; i++)
         begin
            if (e_cnt_reg[i] >= e_div_reg[i])
               e_cnt_reg[i] <= '0;
            else
               e_cnt_reg[i] <= e_cnt_reg[i] + 9'h001;
            e_clk_reg[i] <= ({1'b0, e_cnt_reg[i]} < (({1'b0, e_div_reg[i]} + 10'h002) >> 1));
         end
      end
   end

   // Pin routing: counter select, invert, pairing and general purpose use
   logic [`PCS_NUM_PINS-1:0] pin_reg;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pin_reg <= '0;
      else
      begin
         for (int p = 0; p < `PCS_NUM_PINS; p++)
         begin
            if (pin_gpo_en[p])
               pin_reg[p] <= pin_gpo_data[p];
            else if (diff_mode && p[0])
               pin_reg[p] <= ~(e_clk_reg[pin_cnt_sel[2*(p & 6) +: 2]]
                               ^ pin_invert[p & 6]);
            else
               pin_reg[p] <= e_clk_reg[pin_cnt_sel[2*p +: 2]] ^ pin_invert[p];
         end
      end
   end
   assign external_clock_output = pin_reg;

endmodule : pcs_top
`default_nettype wire

// *** test/pcs_top_chk.sv ***
// Purpose: Port-level assertions for the PLL switchover and reconfiguration block
// Assumes: One sys_clk domain, sys_rst asynchronous active high
// Notes: Bound to pcs_top from the testbench top file
`include "pcs_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pcs_top_chk
   import pcs_pkg::*;
#(
   parameter int unsigned RELOCK_CYCLES = 20
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic auto_switch_en,
   input wire logic ref_sel,
   input wire logic ref_clock_out,
   input wire logic primary_lost,
   input wire logic pll_locked,
   input wire logic cfg_loaded,
   input wire logic [`PCS_DIV_W-1:0] prescale_div,
   input wire logic [`PCS_NUM_ECNT*`PCS_DLY_W-1:0] delay_setting,
   input wire logic [2:0] bw_cp,
   input wire logic [2:0] bw_lf_r,
   input wire logic [1:0] bw_hf_c,
   input wire logic [`PCS_NUM_PINS-1:0] pin_gpo_en,
   input wire logic [`PCS_NUM_PINS-1:0] pin_gpo_data,
   input wire logic [`PCS_NUM_PINS-1:0] external_clock_output
);
   // =====================================================================
   // Cycles spent without lock
   int unsigned unlock_cnt;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         unlock_cnt <= 0;
      else if (pll_locked)
         unlock_cnt <= 0;
      else
         unlock_cnt <= unlock_cnt + 1;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // =====================================================================
   // Properties
   property p_sel_unlocked;
      $changed(ref_sel) |-> !pll_locked;
   endproperty
   a_sel_unlocked: assert property (p_sel_unlocked) else $error("lock high at select change");
   property p_sel_quiet;
      $changed(ref_sel) |-> !ref_clock_out && !$past(ref_clock_out);
   endproperty
   a_sel_quiet: assert property (p_sel_quiet) else $error("reference out active at switch");
   property p_load_pulse;
      cfg_loaded |=> !cfg_loaded;
   endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
   property p_load_unlock;
      cfg_loaded |=> !pll_locked;
   endproperty
   a_load_unlock: assert property (p_load_unlock) else $error("lock kept after load");
   property p_set_by_load;
      $changed(prescale_div) || $changed(delay_setting) |-> $past(cfg_loaded);
   endproperty
   a_set_by_load: assert property (p_set_by_load) else $error("settings moved without load");
   property p_loop_fixed;
      !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable({bw_cp, bw_lf_r, bw_hf_c});
   endproperty
   a_loop_fixed: assert property (p_loop_fixed) else $error("loop settings changed");
   property p_auto_move;
      auto_switch_en && primary_lost && !ref_sel |-> ##[1:12] ref_sel;
   endproperty
   a_auto_move: assert property (p_auto_move) else $error("no automatic switch");
   property p_relock;
      unlock_cnt <= RELOCK_CYCLES + 80;
   endproperty
   a_relock: assert property (p_relock) else $error("relock too slow");
   property p_gpo;
      pin_gpo_en[0] |=> external_clock_output[0] == $past(pin_gpo_data[0]);
   endproperty
   a_gpo: assert property (p_gpo) else $error("pin not following user data");
endmodule : pcs_top_chk
`default_nettype wire

// *** test/pcs_scan_model.sv ***
// Purpose: User logic model shifting the reconfiguration chain
// Assumes: scan_clk high and low each at least two sys_clk cycles
// Notes: Shift clock stands low between frames
`include "pcs_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pcs_scan_model
   import pcs_pkg::*;
(
   input wire logic sys_clk,
   output logic scan_clk,
   output logic scan_data
);
   // =====================================================================
   // Idle levels
   initial
   begin
      scan_clk = 1'b0;
      scan_data = 1'b0;
   end
   // Shift nbits of f, bit 0 first, one rising edge per bit
   task automatic send_bits(input logic [`PCS_CHAIN_LEN-1:0] f, input int nbits);
      for (int i = 0; i < nbits; i++)
      begin
         @(posedge sys_clk) #1;
         scan_data = f[i];
         repeat (3) @(posedge sys_clk);
         #1 scan_clk = 1'b1;
         repeat (3) @(posedge sys_clk);
         #1 scan_clk = 1'b0;
      end
      // Released data line shows the inverse of its last bit
      scan_data = ~scan_data;
   endtask : send_bits
endmodule : pcs_scan_model
`default_nettype wire

// *** test/pcs_top_tb.sv ***
// Purpose: Self-checking bench for the PLL switchover and reconfiguration block
// Assumes: Short relock count in simulation
// Notes: Pin cases run as table rows, the rest by hand
`include "pcs_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module pcs_top_tb
   import pcs_pkg::*;
;
   localparam int unsigned RELOCK_SIM = 20;
   typedef struct packed {
      logic [7:0] en;
      logic [7:0] dat;
      logic [7:0] inv;
      logic dm;
      logic [7:0] exp;
   } pcs_row_t;
   logic sys_clk, sys_rst, primary_ref_clock, secondary_ref_clock, auto_switch_en;
   logic switch_request, ref_sel, ref_clock_out, primary_lost, secondary_lost, pll_locked;
   logic scan_clk, scan_data, scan_aclr, cfg_loaded, diff_mode, prim_run, first_pin;
   logic [8:0] prescale_div, feedback_div;
   logic [19:0] delay_setting;
   logic [2:0] bw_cp_in, bw_lf_r_in, bw_cp, bw_lf_r;
   logic [1:0] bw_hf_c_in, bw_hf_c;
   logic [7:0] pin_invert, pin_gpo_en, pin_gpo_data, external_clock_output;
   logic [15:0] pin_cnt_sel;
   int miscompares, total_checks, cyc, load_seen, load_cyc;
   // =====================================================================
   // Design, partner and clocks
   pcs_top #(.RELOCK_CYCLES(RELOCK_SIM)) dut_u (.sys_clk, .sys_rst, .primary_ref_clock,
      .secondary_ref_clock, .auto_switch_en, .switch_request, .ref_sel, .ref_clock_out,
      .primary_lost, .secondary_lost, .pll_locked, .scan_clk, .scan_data, .scan_aclr,
      .cfg_loaded, .prescale_div, .feedback_div, .delay_setting, .bw_cp_in, .bw_lf_r_in,
      .bw_hf_c_in, .bw_cp, .bw_lf_r, .bw_hf_c, .diff_mode, .pin_cnt_sel,
      .pin_invert, .pin_gpo_en, .pin_gpo_data, .external_clock_output);
   pcs_scan_model scan_u (.sys_clk, .scan_clk, .scan_data);
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial
   begin
      primary_ref_clock = 1'b0;
      forever #80 primary_ref_clock = prim_run & ~primary_ref_clock;
   end
   initial
   begin
      secondary_ref_clock = 1'b0;
      forever #100 secondary_ref_clock = ~secondary_ref_clock;
   end
   // Cycle count and load pulse monitor
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cfg_loaded === 1'b1)
      begin
         load_seen <= load_seen + 1;
         load_cyc <= cyc;
      end
   end
   // =====================================================================
   // Tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic relock();
      for (int i = 0; i < RELOCK_SIM + 70 && pll_locked !== 1'b1; i++)
         tick(1);
      check("relock", pll_locked, 1);
   endtask : relock
   // Manual switch request, then select, lock drop and relock
   task automatic switch_to(input logic v);
      switch_request = 1'b1;
      tick(1);
      switch_request = 1'b0;
      for (int i = 0; i < 100 && ref_sel !== v; i++)
         tick(1);
      check("ref_sel", ref_sel, v);
      check("lock_drop", pll_locked, 0);
      relock();
   endtask : switch_to
   // Full frame with load count, load time and settings
   task automatic load_frame(input logic [`PCS_CHAIN_LEN-1:0] f);
      int t0;
      int seen0;
      t0 = cyc;
      seen0 = load_seen;
      scan_u.send_bits(f, `PCS_CHAIN_LEN);
      tick(4);
      check("loads", load_seen - seen0, 1);
      check("cfg_time", load_cyc - t0 <= `PCS_CONFIG_US * `PCS_CLK_MHZ, 1);
      check("prescale", prescale_div, f[`PCS_N_LSB +: 9]);
      check("feedback", feedback_div, f[`PCS_M_LSB +: 9]);
      check("delays", delay_setting, f[`PCS_DLY_LSB +: 20]);
      check("bw_cp", bw_cp, 3'h5);
      relock();
   endtask : load_frame
   // =====================================================================
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      report_and_stop();
   end
   // =====================================================================
   // Main sequence
   initial
   begin
      pcs_row_t rows [5];
      rows = '{'{8'h00, 8'h00, 8'h00, 1'b0, 8'hFF}, '{8'hFF, 8'hA5, 8'h00, 1'b0, 8'hA5},
         '{8'h00, 8'h00, 8'h0F, 1'b0, 8'hF0}, '{8'h00, 8'h00, 8'h00, 1'b1, 8'h55},
         '{8'hF0, 8'h30, 8'h00, 1'b0, 8'h3F}};
      {miscompares, total_checks, cyc, load_seen, load_cyc} = '0;
      {sys_rst, prim_run} = 2'b11;
      {auto_switch_en, switch_request, scan_aclr, diff_mode} = 4'h0;
      {pin_cnt_sel, pin_invert, pin_gpo_en, pin_gpo_data} = 40'h0000000000;
      {bw_cp_in, bw_lf_r_in, bw_hf_c_in} = {3'h5, 3'h3, 2'h2};
      tick(2);
      check("rst_div", prescale_div, 0);
      check("rst_sel", ref_sel, 0);
      sys_rst = 1'b0;
      tick(1);
      {bw_cp_in, bw_lf_r_in, bw_hf_c_in} = {3'h2, 3'h4, 2'h1};
      tick(3);
      check("bw", {bw_cp, bw_lf_r, bw_hf_c}, {3'h5, 3'h3, 2'h2});
      $display("test reset done");
      foreach (rows[i])
      begin
         {pin_gpo_en, pin_gpo_data, pin_invert, diff_mode} = rows[i][32:8];
         tick(3);
         check("pins", external_clock_output, rows[i].exp);
      end
      $display("test pin table done");
      relock();
      load_frame({5'h15, 5'h00, 5'h0A, 5'h1F, 36'h000000200, 9'h000, 9'h1FF});
      $display("test reconfiguration done");
      // Pin 1 on counter e1 (divide by 2) toggles, pin 0 on e0 (divide by 1) stays high
      {pin_gpo_en, pin_gpo_data, pin_cnt_sel} = {8'h00, 8'h00, 16'h0004};
      tick(3);
      first_pin = external_clock_output[1];
      tick(1);
      check("route_e1", external_clock_output[1] ^ first_pin, 1);
      check("route_e0", external_clock_output[0], 1);
      $display("test routing done");
      scan_u.send_bits({74{1'b1}}, 30);
      scan_aclr = 1'b1;
      tick(1);
      scan_aclr = 1'b0;
      tick(1);
      load_frame({5'h01, 5'h02, 5'h04, 5'h08, 36'h0, 9'h0AA, 9'h155});
      $display("test chain clear done");
      switch_to(1'b1);
      switch_to(1'b0);
      $display("test manual switch done");
      auto_switch_en = 1'b1;
      prim_run = 1'b0;
      for (int i = 0; i < 150 && ref_sel !== 1'b1; i++)
         tick(1);
      check("primary_lost", primary_lost, 1);
      check("auto_sel", ref_sel, 1);
      check("secondary_lost", secondary_lost, 0);
      relock();
      $display("test automatic switch done");
      // Outside logic resets after the lock loss; primary is still dead
      sys_rst = 1'b1;
      tick(2);
      check("rst2_sel", ref_sel, 0);
      check("rst2_lock", pll_locked, 0);
      check("rst2_div", prescale_div, 0);
      sys_rst = 1'b0;
      for (int i = 0; i < 150 && ref_sel !== 1'b1; i++)
         tick(1);
      check("auto_sel2", ref_sel, 1);
      relock();
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule : pcs_top_tb
bind pcs_top pcs_top_chk #(.RELOCK_CYCLES(RELOCK_CYCLES)) chk_u (.sys_clk, .sys_rst,
   .auto_switch_en, .ref_sel, .ref_clock_out, .primary_lost, .pll_locked, .cfg_loaded,
   .prescale_div, .delay_setting, .bw_cp, .bw_lf_r, .bw_hf_c, .pin_gpo_en, .pin_gpo_data,
   .external_clock_output);
`default_nettype wire
